// ---- dv/isp_partner.sv ----
// Application logic sharing the transport-stream mode pin with the device.
// Assumes the device enable is low while the device drives the pin.
`timescale 1ns/1ps
`default_nettype none
module isp_partner (
  // Clock
  input  wire logic clk,
  // Device side of the pin
  input  wire logic tsModePinOut,
  input  wire logic tsModePinOen,
  // Application request
  input  wire logic appDrive,
  input  wire logic appLevel,
  // Resolved pin level
  output logic      pinLevel
);
  logic lastQ = 1'b0;
  // Device wins during a mode handover; a floating pin shows a moving value
  always_comb begin
    if (!tsModePinOen) pinLevel = tsModePinOut;
    else if (appDrive) pinLevel = appLevel;
    else pinLevel = ~lastQ;
  end
  // Last level, so a released pin never repeats it
  always @(posedge clk) lastQ <= pinLevel;
endmodule
`default_nettype wire

// ---- dv/tb_input_select_mode_pins.sv ----
// Self-checking bench of the input select and mode pin block.
// Assumes pins, core and bus are all driven from here on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "isp_cfg.svh"
module tb_input_select_mode_pins
  import isp_pkg::*;
();
  // Clock, reset, bus
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest;
  // Pins and core
  logic carrierDetectPrimary = 1'b1, carrierDetectSecondary = 1'b1, inputSelect = 1'b0;
  logic rateCtrlSource = 1'b0, rateSelect = 1'b0, standardProcessingSkip = 1'b0;
  logic serialInputPrimary = 1'b0, serialInputSecondary = 1'b0, appLevel = 1'b0;
  logic coreLocked = 1'b0, coreAsiDetected = 1'b0, muteQ = 1'b0;
  logic tsModePinIn, tsModePinOut, tsModePinOen, serialSelected, asiDecodeEn, asiAlignEn, locked;
  isp_data_t coreData = '0;
  isp_data_t parallelOut;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] r = 32'h0001_00AF;  // Seed 65711

  isp_top dut_u (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .carrierDetectPrimary, .carrierDetectSecondary,
    .inputSelect, .rateCtrlSource, .rateSelect, .standardProcessingSkip, .tsModePinIn,
    .tsModePinOut, .tsModePinOen, .serialInputPrimary, .serialInputSecondary, .serialSelected,
    .coreLocked, .coreAsiDetected, .coreData, .asiDecodeEn, .asiAlignEn, .locked, .parallelOut
  );
  isp_partner app_u (
    .clk, .tsModePinOut, .tsModePinOen, .appDrive(!rateCtrlSource), .appLevel,
    .pinLevel(tsModePinIn)
  );

  // Clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] expStatus(input logic v, lk, sel, m, ts, en);
    return {m ? 2'b11 : {1'b0, en}, en, ts, m, sel, lk, v};
  endfunction

  task automatic cmpBit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: word got %h exp %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge, released right after that edge;
  // the opening edge keeps two calls in a row from touching the strobe twice in one step
  task automatic busWrite(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Read data taken at the same edge at which waitrequest is sampled low
  task automatic busRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // Outputs and status against the pins now held
  task automatic checkAll();
    logic v, m, ts, en;
    logic [31:0] mask;
    v = inputSelect ? !carrierDetectPrimary : !carrierDetectSecondary;
    m = rateCtrlSource;
    ts = coreLocked & coreAsiDetected & v;
    en = m ? ts : (appLevel & rateSelect & !standardProcessingSkip);
    mask = m ? 32'h0000_00FF : 32'h0000_00EF;  // Pin output is meaningless in slave
    cmpBit(locked, coreLocked & v);
    cmpWord({12'h000, parallelOut}, (v & !muteQ) ? {12'h000, coreData} : 32'h0);
    cmpBit(tsModePinOen, !m);
    if (m) cmpBit(tsModePinOut, ts);
    cmpBit(asiDecodeEn, en);
    cmpBit(asiAlignEn, en);
    cmpBit(serialSelected, inputSelect ? serialInputPrimary : serialInputSecondary);
    busRead(`ISP_OFS_STATUS, rd);
    cmpWord(rd & mask, {24'h0, expStatus(v, coreLocked & v, inputSelect, m, ts, en)} & mask);
    busRead(4'hC, rd);
    cmpWord(rd, 32'h0);
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, random pin sets with corners, crossing delay
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    cmpBit(avs_waitrequest, 1'b1);
    cmpBit(tsModePinOen, 1'b1);
    cmpBit(locked, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    busRead(`ISP_OFS_CTRL, rd);
    cmpWord(rd, 32'h0);
    for (int i = 0; i < 60; i++) begin
      r = lfsr(r);
      if (i % 5 == 0) r = (r & ~32'h0000_002B) | 32'h0000_0050;  // Slave transport corner
      if (i % 5 == 1) r = (r & ~32'h0000_0003) | 32'h0000_0188;  // Master compliant lock
      @(posedge clk);
      carrierDetectPrimary <= r[0];
      carrierDetectSecondary <= r[1];
      inputSelect <= r[2];
      rateCtrlSource <= r[3];
      rateSelect <= r[4];
      standardProcessingSkip <= r[5];
      appLevel <= r[6];
      coreLocked <= r[7];
      coreAsiDetected <= r[8];
      serialInputPrimary <= r[9];
      serialInputSecondary <= r[10];
      coreData <= r[31:12];
      busWrite(`ISP_OFS_CTRL, {31'h0, r[11]}, r[15:12]);
      if (r[12]) muteQ = r[11];
      busWrite(4'h8, 32'hFFFF_FFFF, 4'hF);
      repeat (8) @(posedge clk);
      @(negedge clk);
      checkAll();
    end
    // A carrier drop must not reach the lock output before it is synchronised
    @(posedge clk);
    inputSelect <= 1'b1;
    carrierDetectPrimary <= 1'b0;
    coreLocked <= 1'b1;
    repeat (8) @(posedge clk);
    carrierDetectPrimary <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmpBit(locked, 1'b1);
    repeat (6) @(posedge clk);
    @(negedge clk);
    cmpBit(locked, 1'b0);
    results();
  end
endmodule
`default_nettype wire

// ---- hdl/isp_sync.sv ----
// Three-stage synchroniser for a vector of asynchronous control pins.
// Assumes pins may change at any time; a bit is accepted once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
`include "isp_cfg.svh"
module isp_sync
  import isp_pkg::*;
#(
  parameter int           W   = `ISP_PIN_W,
  parameter logic [W-1:0] RST = `ISP_PIN_RST
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pins
  isp_pin_if.sync   pins
);
  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] st2_q,  st2_d;
  logic [W-1:0] st3_q,  st3_d;
  logic [W-1:0] out_q,  out_d;

  // Stage one feeds only stage two; agreement filters a single-cycle glitch
  always_comb begin
    meta_d = pins.raw;
    st2_d  = meta_q;
    st3_d  = st2_q;
    out_d  = out_q;
    for (int i = 0; i < W; i++) begin
      if (st2_q[i] == st3_q[i]) begin
        out_d[i] = st3_q[i];
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST;
      st2_q  <= RST;
      st3_q  <= RST;
      out_q  <= RST;
    end else begin
      meta_q <= meta_d;
      st2_q  <= st2_d;
      st3_q  <= st3_d;
      out_q  <= out_d;
    end
  end

  assign pins.synced = out_q;
endmodule
`default_nettype wire

// ---- hdl/isp_top.sv ----
// Input selection, carrier validity, output muting and transport-stream mode pin control.
// Assumes the reclocker core supplies lock, stream detection and parallel words on clk,
// and that the pad ring resolves the bidirectional mode pin from its enable.
`timescale 1ns/1ps
`default_nettype none
`include "isp_cfg.svh"
module isp_top
  import isp_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Avalon-MM slave
  input  wire logic [`ISP_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // Asynchronous control pins
  input  wire logic                   carrierDetectPrimary,
  input  wire logic                   carrierDetectSecondary,
  input  wire logic                   inputSelect,
  input  wire logic                   rateCtrlSource,
  input  wire logic                   rateSelect,
  input  wire logic                   standardProcessingSkip,
  // Transport-stream mode pin, three-signal form
  input  wire logic                   tsModePinIn,
  output logic                        tsModePinOut,
  output logic                        tsModePinOen,
  // Serial inputs and selected serial stream
  input  wire logic                   serialInputPrimary,
  input  wire logic                   serialInputSecondary,
  output logic                        serialSelected,
  // Reclocker core
  input  wire logic                   coreLocked,
  input  wire logic                   coreAsiDetected,
  input  wire logic [`ISP_DATA_W-1:0] coreData,
  output logic                        asiDecodeEn,
  output logic                        asiAlignEn,
  // Parallel side
  output logic                        locked,
  output logic      [`ISP_DATA_W-1:0] parallelOut
);
  isp_pin_if pinBus ();

  // All control pins cross into clk before use
  assign pinBus.raw = {standardProcessingSkip, rateSelect, tsModePinIn, rateCtrlSource,
                       inputSelect, carrierDetectSecondary, carrierDetectPrimary};

  isp_sync #(.W(`ISP_PIN_W), .RST(`ISP_PIN_RST)) uSync (
    .clk  (clk),
    .rst  (rst),
    .pins (pinBus.sync)
  );

  logic pSelPri, pCdPri, pCdSec, pMaster, pTsIn, pRate, pSkip;
  assign pCdPri  = pinBus.synced[`ISP_PIN_CD_PRI];
  assign pCdSec  = pinBus.synced[`ISP_PIN_CD_SEC];
  assign pSelPri = pinBus.synced[`ISP_PIN_IN_SEL];
  assign pMaster = pinBus.synced[`ISP_PIN_RATE_SRC];
  assign pTsIn   = pinBus.synced[`ISP_PIN_TS_MODE];
  assign pRate   = pinBus.synced[`ISP_PIN_RATE_SEL];
  assign pSkip   = pinBus.synced[`ISP_PIN_STD_SKIP];

  // Control state
  isp_mode_e mode_q, mode_d;
  logic      valid_q, valid_d;
  logic      selPri_q, selPri_d;
  logic      locked_q, locked_d;
  logic      tsOut_q, tsOut_d;
  logic      tsOen_q, tsOen_d;
  logic      serial_q, serial_d;
  logic      asiDec_q, asiDec_d;
  logic      asiAli_q, asiAli_d;
  isp_data_t par_q, par_d;
  logic      forceMute_q, forceMute_d;
  logic      selCd;

  // Mode decode; slave transport mode needs all three pins as the application set them
  always_comb begin
    if (pMaster) begin
      mode_d = ISP_MD_MASTER;
    end else if (pTsIn && pRate && !pSkip) begin
      mode_d = ISP_MD_SLAVE_TS;
    end else begin
      mode_d = ISP_MD_SLAVE;
    end
  end

  // Input pair selection, validity, lock, muting and mode pin drive
  always_comb begin
    selPri_d = pSelPri;
    selCd    = pSelPri ? pCdPri : pCdSec;
    valid_d  = !selCd;
    serial_d = pSelPri ? serialInputPrimary : serialInputSecondary;
    locked_d = coreLocked && !selCd;
    // Software mute rides on top of the carrier mute, never instead of it
    par_d    = (selCd || forceMute_q) ? '0 : coreData;
    tsOut_d  = 1'b0;
    tsOen_d  = 1'b1;
    asiDec_d = 1'b0;
    asiAli_d = 1'b0;
    unique case (mode_d)
      ISP_MD_MASTER: begin
        tsOen_d  = 1'b0;
        tsOut_d  = coreLocked && coreAsiDetected && !selCd;
        asiDec_d = tsOut_d;
        asiAli_d = tsOut_d;
      end
      ISP_MD_SLAVE_TS: begin
        asiDec_d = 1'b1;
        asiAli_d = 1'b1;
      end
      ISP_MD_SLAVE: begin
        asiDec_d = 1'b0;
        asiAli_d = 1'b0;
      end
    endcase
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q   <= ISP_MD_SLAVE;
      valid_q  <= 1'b0;
      selPri_q <= 1'b0;
      locked_q <= 1'b0;
      tsOut_q  <= 1'b0;
      tsOen_q  <= 1'b1;
      serial_q <= 1'b0;
      asiDec_q <= 1'b0;
      asiAli_q <= 1'b0;
      par_q    <= '0;
    end else begin
      mode_q   <= mode_d;
      valid_q  <= valid_d;
      selPri_q <= selPri_d;
      locked_q <= locked_d;
      tsOut_q  <= tsOut_d;
      tsOen_q  <= tsOen_d;
      serial_q <= serial_d;
      asiDec_q <= asiDec_d;
      asiAli_q <= asiAli_d;
      par_q    <= par_d;
    end
  end

  // Bus slave: one wait cycle, then the access completes; read data is built in the wait cycle
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        busReq;
  assign busReq = avs_read || avs_write;

  always_comb begin
    wait_d      = !(busReq && wait_q);
    rdata_d     = rdata_q;
    forceMute_d = forceMute_q;
    if (busReq && wait_q && avs_read) begin
      rdata_d = 32'h0000_0000; // Unmapped addresses read as zero
      if (avs_address == `ISP_OFS_STATUS) begin
        rdata_d[`ISP_ST_VALID]   = valid_q;
        rdata_d[`ISP_ST_LOCKED]  = locked_q;
        rdata_d[`ISP_ST_SEL_PRI] = selPri_q;
        rdata_d[`ISP_ST_MASTER]  = (mode_q == ISP_MD_MASTER);
        rdata_d[`ISP_ST_TS_MODE] = tsOut_q;
        rdata_d[`ISP_ST_ASI_EN]  = asiDec_q;
        rdata_d[`ISP_ST_MODE_HI:`ISP_ST_MODE_LO] = mode_q;
      end else if (avs_address == `ISP_OFS_CTRL) begin
        rdata_d[`ISP_CTRL_FORCE_MUTE] = forceMute_q;
      end
    end
    // Writes land only at the edge where waitrequest is seen low
    if (avs_write && !wait_q && avs_address == `ISP_OFS_CTRL && avs_byteenable[0]) begin
      forceMute_d = avs_writedata[`ISP_CTRL_FORCE_MUTE];
    end
  end

  // Bus registers
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q      <= 1'b1;
      rdata_q     <= 32'h0000_0000;
      forceMute_q <= `ISP_CTRL_RST;
    end else begin
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
      forceMute_q <= forceMute_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign tsModePinOut    = tsOut_q;
  assign tsModePinOen    = tsOen_q;
  assign serialSelected  = serial_q;
  assign asiDecodeEn     = asiDec_q;
  assign asiAlignEn      = asiAli_q;
  assign locked          = locked_q;
  assign parallelOut     = par_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Helper: carrier of the pair selected one cycle earlier, taken from the synchronised pins
  // rather than from selCd, so a fault in the selection mux cannot hide from the checks
  logic selCdPast;
  always_ff @(posedge clk) begin
    if (rst) begin
      selCdPast <= 1'b1;
    end else begin
      selCdPast <= pSelPri ? pCdPri : pCdSec;
    end
  end

  valid_low_cd_a: assert property (valid_q == !selCdPast) else $error("valid disagrees with carrier");
  mute_on_cd_a: assert property (selCdPast |-> (!locked && parallelOut == '0))
    else $error("invalid input not muted");
  master_mode_a: assert property ($rose(pMaster) |=> mode_q == ISP_MD_MASTER)
    else $error("master mode not entered");
  pin_dir_a: assert property (tsModePinOen == (mode_q != ISP_MD_MASTER))
    else $error("mode pin direction wrong");
  ts_out_a: assert property (tsModePinOut |-> (mode_q == ISP_MD_MASTER && locked && valid_q))
    else $error("mode pin high without lock");
  slave_ts_a: assert property (mode_q == ISP_MD_SLAVE_TS |->
    ($past(pTsIn) && $past(pRate) && !$past(pSkip) && !$past(pMaster)))
    else $error("slave transport mode without pins");
  slave_off_a: assert property ((!pMaster && !pTsIn) |=> (!asiDecodeEn && !asiAlignEn))
    else $error("decode active with mode pin low");
  sel_pri_a: assert property ((pSelPri && $stable(pSelPri)) |=>
    (serialSelected == $past(serialInputPrimary)))
    else $error("primary input not selected");
  sel_sec_a: assert property ((!pSelPri && $stable(pSelPri)) |=>
    (serialSelected == $past(serialInputSecondary)))
    else $error("secondary input not selected");
  // Four samples of a steady high pin are enough for stages two and three to agree
  sync_lat_a: assert property ((inputSelect && !pSelPri) [*4] |=> pSelPri)
    else $error("pin crossing too slow");
  bus_ack_a: assert property ((busReq && wait_q) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest sequence wrong");

  cov_master_ts_c: cover property (mode_q == ISP_MD_MASTER && tsModePinOut);
  cov_slave_ts_c:  cover property (mode_q == ISP_MD_SLAVE_TS);
  cov_mute_c:      cover property ($rose(selCd) ##2 !locked);
  cov_switch_c:    cover property ($fell(pSelPri) ##1 valid_q);
endmodule
`default_nettype wire

// ---- shared/isp_cfg.svh ----
// Constants of the input select and mode pin block: pin indices, offsets, fields, reset values.
// Assumes byte-addressed Avalon-MM access with 32-bit data words.
// Operation
// - Low carrier detect means input valid
// - Invalid input drops lock, mutes parallel outputs
// - Rate control source high selects master mode
// - Mode pin output in master, input in slave
// - Master drives mode pin high on compliant lock
// - Slave transport mode needs high, high, low
// - Slave mode pin low disables decode, alignment
// - Input select high picks primary input pair
// - Input select low picks secondary input pair
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH

// Index of each asynchronous pin in the synchroniser vector
`define ISP_PIN_W        7
`define ISP_PIN_CD_PRI   0
`define ISP_PIN_CD_SEC   1
`define ISP_PIN_IN_SEL   2
`define ISP_PIN_RATE_SRC 3
`define ISP_PIN_TS_MODE  4
`define ISP_PIN_RATE_SEL 5
`define ISP_PIN_STD_SKIP 6
// Both carriers read invalid until the pins have settled
`define ISP_PIN_RST      7'h03

// Register byte offsets
`define ISP_ADDR_W       4
`define ISP_OFS_STATUS   4'h0
`define ISP_OFS_CTRL     4'h4

// Control register fields
`define ISP_CTRL_FORCE_MUTE 0
`define ISP_CTRL_RST        1'h0

// Status register fields
`define ISP_ST_VALID     0
`define ISP_ST_LOCKED    1
`define ISP_ST_SEL_PRI   2
`define ISP_ST_MASTER    3
`define ISP_ST_TS_MODE   4
`define ISP_ST_ASI_EN    5
`define ISP_ST_MODE_LO   6
`define ISP_ST_MODE_HI   7

`define ISP_DATA_W       20
`endif

// ---- shared/isp_pin_if.sv ----
// Carrier between the pin synchroniser and the control logic.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "isp_cfg.svh"
interface isp_pin_if;
  logic [`ISP_PIN_W-1:0] raw;
  logic [`ISP_PIN_W-1:0] synced;

  modport sync (input raw, output synced);
  modport ctrl (output raw, input synced);
endinterface
`default_nettype wire

// ---- shared/isp_pkg.sv ----
// Types of the input select and mode pin block.
// Assumes isp_cfg.svh supplies the widths.
`include "isp_cfg.svh"
package isp_pkg;
  // Operating mode, Gray coded along slave, slave transport, master
  typedef enum logic [1:0] {
    ISP_MD_SLAVE    = 2'b00,
    ISP_MD_SLAVE_TS = 2'b01,
    ISP_MD_MASTER   = 2'b11
  } isp_mode_e;

  typedef logic [`ISP_PIN_W-1:0]  isp_pins_t;
  typedef logic [`ISP_DATA_W-1:0] isp_data_t;
endpackage
